// ---- rtl/iio_top.sv ----
// isolated input and relay output port block with interrupt control byte
`timescale 1ns/1ps
module iio_top
   import iio_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // host byte port
   input wire logic [2:0] addr_i,
   input wire logic rd_i,
   input wire logic wr_i,
   input wire logic [7:0] wdata_i,
   output logic [7:0] rdata_o,
   output logic irq_o,
   // isolator outputs, low when voltage applied
   input wire logic [7:0] iso_low_i,
   input wire logic [7:0] iso_high_i,
   // relay coil drive, high closes relay
   output logic [7:0] relay_low_o,
   output logic [7:0] relay_high_o
);
   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   logic [7:0] in_low;
   logic [7:0] in_high;

   iio_sync u_sync_low (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .async_i(iso_low_i),
      .sync_o(in_low)
   );

   iio_sync u_sync_high (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .async_i(iso_high_i),
      .sync_o(in_high)
   );

   // ----------------------------------------
   // state registers
   // ----------------------------------------
   iio_state_t r;
   iio_state_t next_r;

   // ----------------------------------------
   // access decode
   // ----------------------------------------
   // unmapped offsets match no strobe; a read there still loads zero into the read data
   // read strobes
   logic rd_in_low;
   logic rd_in_high;
   logic rd_relay_low;
   logic rd_relay_high;
   logic rd_zero;
   logic rd_irq;
   // write strobes
   logic wr_relay_low;
   logic wr_relay_high;
   logic wr_irq;

   assign rd_in_low = rd_i && (addr_i == IIO_OFS_IN_LOW);
   assign rd_in_high = rd_i && (addr_i == IIO_OFS_IN_HIGH);
   assign rd_relay_low = rd_i && (addr_i == IIO_OFS_RELAY_LOW);
   assign rd_relay_high = rd_i && (addr_i == IIO_OFS_RELAY_HIGH);
   assign rd_zero = rd_i && (addr_i == IIO_OFS_ZERO);
   assign rd_irq = rd_i && (addr_i == IIO_OFS_IRQ);
   assign wr_relay_low = wr_i && (addr_i == IIO_OFS_RELAY_LOW);
   assign wr_relay_high = wr_i && (addr_i == IIO_OFS_RELAY_HIGH);
   assign wr_irq = wr_i && (addr_i == IIO_OFS_IRQ);

   // ----------------------------------------
   // interrupt event terms
   // ----------------------------------------
   logic src;
   logic [1:0] mode;
   logic hit;
   logic pending;
   logic level_mode;
   logic set_evt;
   logic clr_read;
   logic clr_level;
   logic clr_off;

   // edges need the previous synchronised sample, never the raw pin
   // prev resets high, matching the idle input, so no false edge follows reset
   function automatic logic event_hit(input logic [1:0] sel, input logic prev, input logic now);
      logic result;
      result = 1'b0;
      case (sel)
         IIO_MODE_LOW_LEVEL: result = !now;
         IIO_MODE_HIGH_LEVEL: result = now;
         IIO_MODE_FALL_EDGE: result = prev && !now;
         IIO_MODE_RISE_EDGE: result = !prev && now;
         default: result = 1'b0;
      endcase
      return result;
   endfunction

   assign src = in_low[0];
   assign mode = {r.irq_type_sel_hi, r.irq_type_sel_lo};
   assign hit = event_hit(mode, r.src_prev, src);
   assign pending = (r.irq_state == IIO_ST_PENDING);
   assign level_mode = !r.irq_type_sel_hi;
   assign set_evt = hit && r.irq_enable_bit;
   // set wins over the read clear; a held level keeps pending through the read
   assign clr_read = rd_irq && !hit;
   assign clr_level = level_mode && !hit;
   // dropping the enable also drops what is pending
   assign clr_off = !r.irq_enable_bit;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   logic [7:0] irq_byte;

   // one copy of the state is filled here and registered below
   always_comb begin
      next_r = r;
      // unused bits of the irq byte read as zero
      irq_byte = 8'h00;
      irq_byte[IIO_IRQ_ENABLE_POS] = r.irq_enable_bit;
      irq_byte[IIO_IRQ_PENDING_POS] = pending;
      irq_byte[IIO_IRQ_SEL_HI_POS] = r.irq_type_sel_hi;
      irq_byte[IIO_IRQ_SEL_LO_POS] = r.irq_type_sel_lo;
      next_r.src_prev = src;
      // read data, registered one cycle after the strobe, held otherwise
      if (rd_in_low) begin
         next_r.rdata = in_low;
      end else if (rd_in_high) begin
         next_r.rdata = in_high;
      end else if (rd_relay_low) begin
         next_r.rdata = ~r.relay_low;
      end else if (rd_relay_high) begin
         next_r.rdata = ~r.relay_high;
      end else if (rd_irq) begin
         next_r.rdata = irq_byte;
      end else if (rd_zero) begin
         next_r.rdata = 8'h00;
      end else if (rd_i) begin
         next_r.rdata = 8'h00;
      end
      // relays hold their drive until written; reads never move them
      if (wr_relay_low) begin
         next_r.relay_low = wdata_i;
      end
      if (wr_relay_high) begin
         next_r.relay_high = wdata_i;
      end
      if (wr_irq) begin
         next_r.irq_enable_bit = wdata_i[IIO_IRQ_ENABLE_POS];
         next_r.irq_type_sel_hi = wdata_i[IIO_IRQ_SEL_HI_POS];
         next_r.irq_type_sel_lo = wdata_i[IIO_IRQ_SEL_LO_POS];
      end
      // pending holds until one of its clear terms fires
      case (r.irq_state)
         IIO_ST_IDLE: begin
            if (set_evt) begin
               next_r.irq_state = IIO_ST_PENDING;
            end
         end
         IIO_ST_PENDING: begin
            if (clr_off) begin
               next_r.irq_state = IIO_ST_IDLE;
            end else if (clr_read) begin
               next_r.irq_state = IIO_ST_IDLE;
            end else if (clr_level) begin
               next_r.irq_state = IIO_ST_IDLE;
            end
         end
         default: begin
            next_r.irq_state = IIO_ST_IDLE;
         end
      endcase
      next_r.irq = (next_r.irq_state == IIO_ST_PENDING);
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         r.relay_low <= IIO_RELAY_RESET;
         r.relay_high <= IIO_RELAY_RESET;
         r.irq_enable_bit <= 1'b0;
         r.irq_type_sel_hi <= IIO_MODE_RESET[1];
         r.irq_type_sel_lo <= IIO_MODE_RESET[0];
         r.irq_state <= IIO_ST_IDLE;
         r.src_prev <= 1'b1;
         r.rdata <= 8'h00;
         r.irq <= 1'b0;
      end else begin
         r <= next_r;
      end
   end

   // ----------------------------------------
   // outputs straight from flops
   // ----------------------------------------
   assign rdata_o = r.rdata;
   assign irq_o = r.irq;
   assign relay_low_o = r.relay_low;
   assign relay_high_o = r.relay_high;
endmodule

// ---- shared/iio_pkg.sv ----
// package: register map, field positions and reset values of the isolated i/o block
package iio_pkg;
   // ----------------------------------------
   // register offsets
   // ----------------------------------------
   localparam logic [2:0] IIO_OFS_IN_LOW = 3'h0;
   localparam logic [2:0] IIO_OFS_IN_HIGH = 3'h1;
   localparam logic [2:0] IIO_OFS_RELAY_LOW = 3'h2;
   localparam logic [2:0] IIO_OFS_RELAY_HIGH = 3'h3;
   localparam logic [2:0] IIO_OFS_ZERO = 3'h4;
   localparam logic [2:0] IIO_OFS_IRQ = 3'h5;
   // ----------------------------------------
   // interrupt control/status field positions
   // ----------------------------------------
   localparam int IIO_IRQ_ENABLE_POS = 7;
   localparam int IIO_IRQ_PENDING_POS = 6;
   localparam int IIO_IRQ_SEL_HI_POS = 1;
   localparam int IIO_IRQ_SEL_LO_POS = 0;
   // ----------------------------------------
   // reset values and modes
   // ----------------------------------------
   localparam logic [7:0] IIO_RELAY_RESET = 8'h00;
   localparam logic [7:0] IIO_INPUT_IDLE = 8'hFF;
   localparam logic [1:0] IIO_MODE_RESET = 2'h0;
   localparam logic [1:0] IIO_MODE_LOW_LEVEL = 2'h0;
   localparam logic [1:0] IIO_MODE_HIGH_LEVEL = 2'h1;
   localparam logic [1:0] IIO_MODE_FALL_EDGE = 2'h2;
   localparam logic [1:0] IIO_MODE_RISE_EDGE = 2'h3;

   typedef enum logic [1:0] {
      IIO_ST_IDLE = 2'b01,
      IIO_ST_PENDING = 2'b10
   } iio_irq_state_t;

   typedef struct packed {
      logic [7:0] stage1;
      logic [7:0] stage2;
   } iio_sync_t;

   typedef struct packed {
      logic [7:0] relay_low;
      logic [7:0] relay_high;
      logic irq_enable_bit;
      logic irq_type_sel_hi;
      logic irq_type_sel_lo;
      iio_irq_state_t irq_state;
      logic src_prev;
      logic [7:0] rdata;
      logic irq;
   } iio_state_t;
endpackage

// ---- rtl/iio_sync.sv ----
// two-flop synchroniser for one isolated input byte
`timescale 1ns/1ps
module iio_sync
   import iio_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // data
   input wire logic [7:0] async_i,
   output logic [7:0] sync_o
);
   iio_sync_t r;
   iio_sync_t next_r;

   always_comb begin
      next_r = r;
      next_r.stage1 = async_i;
      next_r.stage2 = r.stage1;
   end

   // idle level so no spurious level irq right after reset
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         r <= {IIO_INPUT_IDLE, IIO_INPUT_IDLE};
      end else begin
         r <= next_r;
      end
   end

   assign sync_o = r.stage2;
endmodule

// ---- dv/iio_props.sv ----
// checker: port properties of the isolated i/o block
`timescale 1ns/1ps
module iio_props
   import iio_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // watched ports
   input wire logic [2:0] addr_i,
   input wire logic rd_i,
   input wire logic wr_i,
   input wire logic [7:0] wdata_i,
   input wire logic [7:0] rdata_o,
   input wire logic irq_o,
   input wire logic [7:0] iso_low_i,
   input wire logic [7:0] iso_high_i,
   input wire logic [7:0] relay_low_o,
   input wire logic [7:0] relay_high_o
);
   // ----
   // properties
   // ----
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   // synchroniser settled only once the input sat still
   sequence s_in_steady;
      $stable(iso_low_i) [*3] ##0 $past(reset_n_i, 4);
   endsequence
   // enable written to zero
   sequence s_irq_off_write;
      wr_i && addr_i == IIO_OFS_IRQ && !wdata_i[IIO_IRQ_ENABLE_POS];
   endsequence
   a_relay_write: assert property (wr_i && addr_i == IIO_OFS_RELAY_LOW
      |=> relay_low_o == $past(wdata_i))
      else $error("relay write lost");
   a_relay_hold: assert property (!(wr_i && addr_i == IIO_OFS_RELAY_LOW) |=> $stable(relay_low_o))
      else $error("relay changed unasked");
   a_relay_readback: assert property (rd_i && addr_i == IIO_OFS_RELAY_HIGH
      |=> rdata_o == ~$past(relay_high_o))
      else $error("relay readback not inverted");
   a_zero_byte: assert property (rd_i && addr_i == IIO_OFS_ZERO |=> rdata_o == 8'h00)
      else $error("zero byte not zero");
   a_irq_byte: assert property (rd_i && addr_i == IIO_OFS_IRQ
      |=> rdata_o[5:2] == 4'h0 && rdata_o[6] == $past(irq_o))
      else $error("irq byte wrong");
   a_rdata_hold: assert property (!rd_i |=> $stable(rdata_o))
      else $error("read data moved");
   a_input_read: assert property (s_in_steady ##0 (rd_i && addr_i == IIO_OFS_IN_LOW)
      |=> rdata_o == $past(iso_low_i))
      else $error("input byte wrong");
   a_reset_state: assert property ($rose(reset_n_i)
      |-> relay_low_o == 8'h00 && relay_high_o == 8'h00 && !irq_o)
      else $error("reset state wrong");
   a_irq_drop: assert property (s_irq_off_write |=> ##1 !irq_o)
      else $error("irq kept while disabled");
endmodule
bind iio_top iio_props u_props (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .rd_i(rd_i), .wr_i(wr_i),
   .wdata_i(wdata_i), .rdata_o(rdata_o), .irq_o(irq_o), .iso_low_i(iso_low_i), .iso_high_i(iso_high_i),
   .relay_low_o(relay_low_o), .relay_high_o(relay_high_o));

// ---- dv/iio_host.sv ----
// host model: byte-port master for register cycles
`timescale 1ns/1ps
module iio_host
   import iio_pkg::*;
(
   // clock
   input wire logic clk_i,
   // byte port
   output logic [2:0] addr_o,
   output logic rd_o,
   output logic wr_o,
   output logic [7:0] wdata_o,
   input wire logic [7:0] rdata_i
);
   initial {addr_o, rd_o, wr_o, wdata_o} = '0;
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_i);
      #1 {addr_o, wr_o, wdata_o} = {a, 1'b1, d};
      @(posedge clk_i);
      #1 {wr_o, wdata_o} = {1'b0, ~d};
   endtask
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk_i);
      #1 {addr_o, rd_o} = {a, 1'b1};
      @(posedge clk_i);
      #1 rd_o = 1'b0;
      d = rdata_i;
   endtask
   // mode set while disabled, else a stale edge fires
   task automatic set_mode(input logic [1:0] m);
      wr(IIO_OFS_IRQ, {6'h00, m});
      wr(IIO_OFS_IRQ, {6'h20, m});
   endtask
endmodule

// ---- dv/iio_top_tb.sv ----
// testbench: random and corner checks of the isolated i/o block
`timescale 1ns/1ps
module iio_top_tb
   import iio_pkg::*;
;
   logic clk_i = 0;
   logic reset_n_i = 0;
   logic [2:0] addr;
   logic rd, wr, irq;
   logic [7:0] wdata, rdata, rly_lo, rly_hi, v, d;
   logic [7:0] iso_lo = 8'hFF;
   logic [7:0] iso_hi = 8'hFF;
   logic [31:0] seed = 32'h3d1b;
   logic [1:0] m;
   int miscompares = 0;
   int n_checks = 0;
   int cycles = 0;
   always #25 clk_i = ~clk_i;
   iio_host host (.clk_i(clk_i), .addr_o(addr), .rd_o(rd), .wr_o(wr), .wdata_o(wdata), .rdata_i(rdata));
   iio_top uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr), .rd_i(rd), .wr_i(wr), .wdata_i(wdata),
      .rdata_o(rdata), .irq_o(irq), .iso_low_i(iso_lo), .iso_high_i(iso_hi), .relay_low_o(rly_lo),
      .relay_high_o(rly_hi));
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("FAIL %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict();
      if (miscompares == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         give_verdict();
      end
   end
   initial begin
      repeat (16) @(posedge clk_i);
      #1 reset_n_i = 1;
      host.rd(IIO_OFS_RELAY_LOW, v);
      chk(v, 8'hFF);
      host.rd(IIO_OFS_IRQ, v);
      chk(v, 8'h00);
      for (int i = 0; i < 8; i++) begin
         d = (i == 0) ? 8'hFF : rnd();
         host.wr(IIO_OFS_RELAY_LOW, d);
         host.wr(IIO_OFS_RELAY_HIGH, ~d);
         host.wr(i[0] ? IIO_OFS_ZERO : IIO_OFS_IN_LOW, rnd());
         chk(rly_lo, d);
         chk(rly_hi, ~d);
         host.rd(IIO_OFS_RELAY_LOW, v);
         chk(v, ~d);
         host.rd(IIO_OFS_RELAY_HIGH, v);
         chk(v, d);
         iso_lo = rnd();
         iso_hi = rnd();
         host.rd(3'h7, v);
         chk(v, 8'h00);
         host.rd(IIO_OFS_IN_LOW, v);
         chk(v, iso_lo);
         host.rd(IIO_OFS_IN_HIGH, v);
         chk(v, iso_hi);
         host.rd(IIO_OFS_ZERO, v);
         chk(v, 8'h00);
      end
      for (int k = 0; k < 4; k++) begin
         m = k[1:0];
         iso_lo[0] = ~m[0];
         host.set_mode(m);
         repeat (4) @(posedge clk_i);
         #1 chk({7'h00, irq}, 8'h00);
         iso_lo[0] = m[0];
         repeat (4) @(posedge clk_i);
         #1 chk({7'h00, irq}, 8'h01);
         host.rd(IIO_OFS_IRQ, v);
         chk(v, {2'h3, 4'h0, m});
         chk({7'h00, irq}, {7'h00, ~m[1]});
         iso_lo[0] = ~m[0];
         repeat (4) @(posedge clk_i);
         #1 chk({7'h00, irq}, 8'h00);
         host.wr(IIO_OFS_IRQ, 8'h00);
         iso_lo[0] = m[0];
         repeat (4) @(posedge clk_i);
         #1 chk({7'h00, irq}, 8'h00);
      end
      // pending edge dropped by clearing the enable
      iso_lo[0] = 1'b1;
      host.set_mode(IIO_MODE_FALL_EDGE);
      iso_lo[0] = 1'b0;
      repeat (4) @(posedge clk_i);
      #1 chk({7'h00, irq}, 8'h01);
      host.wr(IIO_OFS_IRQ, 8'h02);
      repeat (2) @(posedge clk_i);
      #1 chk({7'h00, irq}, 8'h00);
      host.rd(IIO_OFS_IRQ, v);
      chk(v, 8'h02);
      // reset in mid-run with relays driven
      host.wr(IIO_OFS_RELAY_LOW, 8'hA5);
      @(posedge clk_i);
      #1 reset_n_i = 0;
      repeat (2) @(posedge clk_i);
      #1 chk(rly_lo, 8'h00);
      reset_n_i = 1;
      host.rd(IIO_OFS_IRQ, v);
      chk(v, 8'h00);
      host.rd(IIO_OFS_RELAY_HIGH, v);
      chk(v, 8'hFF);
      give_verdict();
   end
endmodule
